// [verilog/cap_ctrl_pkg.sv]
// Constants for the capacitance converter power and calibration control.
// Assumes a 250 MHz core clock and a 10-bit significant register address.
package cap_ctrl_pkg;

	localparam int          ADDR_W          = 16;
	localparam int          ADDR_SIG_W      = 10;
	localparam int          DATA_W          = 16;
	localparam logic [9:0]  POWER_CONTROL_IDX            = 10'h000;
	localparam logic [9:0]  STAGE_CALIBRATION_ENABLE_IDX = 10'h001;
	localparam logic [15:0] POWER_CONTROL_RST            = 16'h0000;
	localparam logic [15:0] STAGE_CALIBRATION_ENABLE_RST = 16'h0000;

	// power_control fields
	localparam int MODE_LSB       = 0;
	localparam int DELAY_LSB      = 2;
	localparam int STAGES_LSB     = 4;
	localparam int DECIM_LSB      = 8;
	localparam int SWRST_BIT      = 10;
	localparam int INTPOL_BIT     = 11;
	localparam int EXCDIS_BIT     = 12;
	localparam int UNUSED_BIT     = 13;
	localparam int BIAS_LSB       = 14;
	// stage_calibration_enable fields
	localparam int NUM_STAGES     = 12;
	localparam int FP_SKIP_LSB    = 12;
	localparam int LP_SKIP_LSB    = 14;
	localparam logic [3:0] MAX_STAGE_CODE = 4'hb;

	localparam logic [1:0] MODE_FULL     = 2'h0;
	localparam logic [1:0] MODE_SHUT_A   = 2'h1;
	localparam logic [1:0] MODE_LOW      = 2'h2;
	localparam logic [1:0] MODE_SHUT_B   = 2'h3;

	// Timing
	localparam longint CLK_HZ          = 250000000;
	localparam longint FP_PERIOD_MS    = 36;
	localparam longint LP_DELAY_UNIT_MS = 200;
	localparam longint FP_PERIOD_CYC   = FP_PERIOD_MS * CLK_HZ / 1000;
	localparam longint LP_UNIT_CYC     = LP_DELAY_UNIT_MS * CLK_HZ / 1000;

	localparam logic [8:0] DECIM_256 = 9'h100;
	localparam logic [8:0] DECIM_128 = 9'h080;
	localparam logic [8:0] DECIM_64  = 9'h040;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10
	} seq_state_t;

endpackage

// [verilog/cfg_if.sv]
`timescale 1ns/1ps
// Decoded configuration passed from the register file to the sequencer.
// Assumes both ends share the core clock.
interface cfg_if;
	logic [1:0] mode;
	logic [1:0] lp_delay;
	logic [3:0] stage_code;
	modport src (output mode, output lp_delay, output stage_code);
	modport dst (input mode, input lp_delay, input stage_code);
endinterface

// [verilog/conv_sequencer.sv]
`timescale 1ns/1ps
// Conversion sequencer: timing of sequences per operating mode.
// Assumes configuration stable or changing at any time; mode or delay change restarts.
module conv_sequencer #(
	parameter longint FP_CYC = cap_ctrl_pkg::FP_PERIOD_CYC,
	parameter longint LP_CYC = cap_ctrl_pkg::LP_UNIT_CYC
) (
	input  wire logic clk,          // Core clock
	input  wire logic rst,          // Synchronous reset
	cfg_if.dst        cfg,          // Decoded settings
	output logic      conv_start,   // Pulse: start one stage conversion
	output logic [3:0] conv_stage,  // Stage being converted
	output logic      seq_busy      // Sequence in progress
);
	cap_ctrl_pkg::seq_state_t st_q, st_d;
	logic [31:0] wait_q, wait_d;
	logic [3:0]  stage_q, stage_d;
	logic        start_q, start_d;
	logic [1:0]  mode_q, delay_q;

	function automatic logic [31:0] wait_len(input logic [1:0] m,
		input logic [1:0] d);
		if (m == cap_ctrl_pkg::MODE_LOW)
			wait_len = 32'(LP_CYC * (longint'(d) + 1));
		else
			wait_len = 32'(FP_CYC);
	endfunction

	function automatic logic shut(input logic [1:0] m);
		shut = m[0];
	endfunction

	always_comb begin
		st_d    = st_q;
		wait_d  = wait_q;
		stage_d = stage_q;
		start_d = 1'b0;
		case (st_q)
			cap_ctrl_pkg::ST_IDLE: begin
				if (!shut(cfg.mode)) begin
					st_d   = cap_ctrl_pkg::ST_WAIT;
					wait_d = wait_len(cfg.mode, cfg.lp_delay);
				end
			end
			cap_ctrl_pkg::ST_WAIT: begin
				if (wait_q <= 32'd1) begin
					st_d    = cap_ctrl_pkg::ST_CONV;
					stage_d = 4'h0;
					start_d = 1'b1;
				end else begin
					wait_d = wait_q - 32'd1;
				end
			end
			cap_ctrl_pkg::ST_CONV: begin
				if (stage_q >= cfg.stage_code ||
				    stage_q >= cap_ctrl_pkg::MAX_STAGE_CODE) begin
					st_d   = cap_ctrl_pkg::ST_WAIT;
					wait_d = wait_len(cfg.mode, cfg.lp_delay);
				end else begin
					stage_d = stage_q + 4'h1;
					start_d = 1'b1;
				end
			end
			default: st_d = cap_ctrl_pkg::ST_IDLE;
		endcase
		// Mode or delay change restarts timing from idle
		if (shut(cfg.mode) || cfg.mode != mode_q ||
		    cfg.lp_delay != delay_q) begin
			st_d    = cap_ctrl_pkg::ST_IDLE;
			start_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q    <= cap_ctrl_pkg::ST_IDLE;
			wait_q  <= 32'h0;
			stage_q <= 4'h0;
			start_q <= 1'b0;
			mode_q  <= cap_ctrl_pkg::MODE_FULL;
			delay_q <= 2'h0;
		end else begin
			st_q    <= st_d;
			wait_q  <= wait_d;
			stage_q <= stage_d;
			start_q <= start_d;
			mode_q  <= cfg.mode;
			delay_q <= cfg.lp_delay;
		end
	end

	assign conv_start = start_q;
	assign conv_stage = stage_q;
	assign seq_busy   = (st_q == cap_ctrl_pkg::ST_CONV);
endmodule

// [verilog/cap_power_cal_ctrl.sv]
`timescale 1ns/1ps
// Power and calibration control registers with decoded control outputs.
// Assumes the serial front end delivers decoded 16-bit register accesses.

// Overview of operation
// - Mode 00 is full power with sequences about every 36 ms.
// - Modes 01 and 11 shut the converter down with no conversions.
// - Mode 10 is low power with automatic wake-up conversions.
// - In low power the sequence delay is 200, 400, 600 or 800 ms.
// - Stages per sequence equal bits 7:4 plus one, at most 12.
// - Bits 9:8 decimate by 256, 128, 64 or 64.
// - Writing one to bit 10 resets all registers and self-clears.
// - Bit 12 set disables excitation to the sensor input pins.
// - Bits 15:14 select nominal or +20, +35, +50 percent bias.
// - Full power skip bits 13:12 choose 3, 7, 15 or 31 samples.
// - Low power skip bits 15:14 choose skipping zero to three.
module cap_power_cal_ctrl #(
	parameter longint FP_CYC = cap_ctrl_pkg::FP_PERIOD_CYC,
	parameter longint LP_CYC = cap_ctrl_pkg::LP_UNIT_CYC
) (
	input  wire logic        clk,            // Core clock
	input  wire logic        rst,            // Synchronous reset
	input  wire logic        reg_wr,         // Write strobe
	input  wire logic        reg_rd,         // Read strobe
	input  wire logic [15:0] reg_addr,       // Register address
	input  wire logic [15:0] reg_wdata,      // Write data
	output logic      [15:0] reg_rdata,      // Read data
	output logic             reg_rvalid,     // Read data valid pulse
	input  wire logic        irq_event,      // Internal interrupt request
	output logic             irq_pin,        // Interrupt pin level
	output logic             excitation_en,  // Excitation on sensor pins
	output logic       [1:0] converter_bias_select, // Bias current code
	output logic       [8:0] decimation_ratio,      // Decimation factor
	output logic             conv_start,     // Stage conversion pulse
	output logic       [3:0] conv_stage,     // Stage index
	output logic             conv_cal_en,    // Calibrate this stage
	output logic       [5:0] sample_skip,    // Samples skipped
	output logic             seq_busy,       // Sequence running
	output logic             powered_down    // Shutdown mode active
);
	logic [15:0] pwr_q, pwr_d;
	logic [15:0] cal_q, cal_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        irq_q, irq_d;
	logic        exc_q, exc_d;
	logic [1:0]  bias_q, bias_d;
	logic [8:0]  dec_q, dec_d;
	logic [5:0]  skip_q, skip_d;
	logic [9:0]  idx;
	logic [1:0]  mode;
	logic        seq_start;
	logic [3:0]  seq_stage;

	cfg_if cfg_bus ();

	assign idx  = reg_addr[cap_ctrl_pkg::ADDR_SIG_W-1:0];
	assign mode = pwr_q[cap_ctrl_pkg::MODE_LSB +: 2];

	assign cfg_bus.mode       = mode;
	assign cfg_bus.lp_delay   = pwr_q[cap_ctrl_pkg::DELAY_LSB +: 2];
	assign cfg_bus.stage_code = pwr_q[cap_ctrl_pkg::STAGES_LSB +: 4];

	function automatic logic [8:0] decim(input logic [1:0] c);
		case (c)
			2'h0:    decim = cap_ctrl_pkg::DECIM_256;
			2'h1:    decim = cap_ctrl_pkg::DECIM_128;
			default: decim = cap_ctrl_pkg::DECIM_64;
		endcase
	endfunction

	function automatic logic [5:0] skip_cnt(input logic [1:0] m,
		input logic [15:0] cal);
		logic [1:0] c;
		c = cal[cap_ctrl_pkg::FP_SKIP_LSB +: 2];
		if (m == cap_ctrl_pkg::MODE_LOW)
			skip_cnt = {4'h0, cal[cap_ctrl_pkg::LP_SKIP_LSB +: 2]};
		else
			skip_cnt = 6'((6'h4 << c) - 6'h1);
	endfunction

	always_comb begin
		pwr_d    = pwr_q;
		cal_d    = cal_q;
		rdata_d  = rdata_q;
		rvalid_d = reg_rd;
		if (reg_wr && idx == cap_ctrl_pkg::POWER_CONTROL_IDX) begin
			pwr_d = reg_wdata;
			// Unused bit kept zero; reset bit never stored
			pwr_d[cap_ctrl_pkg::UNUSED_BIT] = 1'b0;
			pwr_d[cap_ctrl_pkg::SWRST_BIT]  = 1'b0;
		end
		if (reg_wr && idx == cap_ctrl_pkg::STAGE_CALIBRATION_ENABLE_IDX)
			cal_d = reg_wdata;
		if (reg_wr && idx == cap_ctrl_pkg::POWER_CONTROL_IDX &&
		    reg_wdata[cap_ctrl_pkg::SWRST_BIT]) begin
			pwr_d = cap_ctrl_pkg::POWER_CONTROL_RST;
			cal_d = cap_ctrl_pkg::STAGE_CALIBRATION_ENABLE_RST;
		end
		if (reg_rd) begin
			case (idx)
				cap_ctrl_pkg::POWER_CONTROL_IDX:            rdata_d = pwr_q;
				cap_ctrl_pkg::STAGE_CALIBRATION_ENABLE_IDX: rdata_d = cal_q;
				default:                                    rdata_d = 16'h0000;
			endcase
		end
		// Outputs follow the stored registers one cycle later
		irq_d  = irq_event ~^ pwr_q[cap_ctrl_pkg::INTPOL_BIT];
		exc_d  = ~pwr_q[cap_ctrl_pkg::EXCDIS_BIT];
		bias_d = pwr_q[cap_ctrl_pkg::BIAS_LSB +: 2];
		dec_d  = decim(pwr_q[cap_ctrl_pkg::DECIM_LSB +: 2]);
		skip_d = skip_cnt(mode, cal_q);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_q    <= cap_ctrl_pkg::POWER_CONTROL_RST;
			cal_q    <= cap_ctrl_pkg::STAGE_CALIBRATION_ENABLE_RST;
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
			irq_q    <= 1'b1;
			exc_q    <= 1'b1;
			bias_q   <= 2'h0;
			dec_q    <= cap_ctrl_pkg::DECIM_256;
			skip_q   <= 6'h03;
		end else begin
			pwr_q    <= pwr_d;
			cal_q    <= cal_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			irq_q    <= irq_d;
			exc_q    <= exc_d;
			bias_q   <= bias_d;
			dec_q    <= dec_d;
			skip_q   <= skip_d;
		end
	end

	conv_sequencer #(
		.FP_CYC (FP_CYC),
		.LP_CYC (LP_CYC)
	) u_seq (
		.clk        (clk),
		.rst        (rst),
		.cfg        (cfg_bus.dst),
		.conv_start (seq_start),
		.conv_stage (seq_stage),
		.seq_busy   (seq_busy)
	);

	assign conv_start  = seq_start;
	assign conv_stage  = seq_stage;
	// Stage index never passes 11, so the select stays in range
	assign conv_cal_en = cal_q[seq_stage];
	assign powered_down = mode[0];
	assign reg_rdata   = rdata_q;
	assign reg_rvalid  = rvalid_q;
	assign irq_pin     = irq_q;
	assign excitation_en = exc_q;
	assign converter_bias_select = bias_q;
	assign decimation_ratio = dec_q;
	assign sample_skip = skip_q;
endmodule

// [tb/cap_ctrl_properties.sv]
// Checker for the power and calibration control ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cap_ctrl_properties (
	input wire logic        clk,                   // Core clock
	input wire logic        rst,                   // Sync reset
	input wire logic        reg_wr,                // Write strobe
	input wire logic        reg_rd,                // Read strobe
	input wire logic [15:0] reg_addr,              // Address
	input wire logic [15:0] reg_wdata,             // Write data
	input wire logic        reg_rvalid,            // Read valid
	input wire logic        irq_event,             // Interrupt request
	input wire logic        irq_pin,               // Interrupt pin
	input wire logic        excitation_en,         // Excitation on
	input wire logic [1:0]  converter_bias_select, // Bias code
	input wire logic [8:0]  decimation_ratio,      // Decimation
	input wire logic        conv_start,            // Stage start
	input wire logic [3:0]  conv_stage,            // Stage index
	input wire logic        powered_down           // Shutdown
);
	logic wr0;
	logic pol_q;
	logic pol_d;
	assign wr0 = reg_wr && reg_addr[9:0] == 10'h000;
	// Mirror of the polarity bit; a soft reset clears it too
	always_comb begin
		pol_d = pol_q;
		if (wr0)
			pol_d = reg_wdata[11] && !reg_wdata[10];
	end
	always_ff @(posedge clk) begin
		pol_q <= rst ? 1'b0 : pol_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read valid without read");
	a_excite_gate: assert property (wr0 && !reg_wdata[10] |-> ##2
		excitation_en == !$past(reg_wdata[12], 2))
		else $error("excitation enable wrong");
	a_bias_field: assert property (wr0 && !reg_wdata[10] |-> ##2
		converter_bias_select == $past(reg_wdata[15:14], 2))
		else $error("bias code wrong");
	a_decim_map: assert property (wr0 && !reg_wdata[10] |-> ##2
		decimation_ratio == ($past(reg_wdata[9], 2) ? 9'h040 :
		$past(reg_wdata[8], 2) ? 9'h080 : 9'h100))
		else $error("decimation wrong");
	a_soft_reset: assert property (wr0 && reg_wdata[10] |-> ##2
		decimation_ratio == 9'h100 && excitation_en &&
		converter_bias_select == 2'h0)
		else $error("soft reset left state");
	a_irq_level: assert property (
		irq_pin == ($past(irq_event) ~^ $past(pol_q)))
		else $error("interrupt pin level wrong");
	a_shut_idle: assert property (
		powered_down && $past(powered_down) |-> !conv_start)
		else $error("conversion in shutdown");
	a_first_stage: assert property (
		$rose(conv_start) |-> conv_stage == 4'h0)
		else $error("sequence not from stage zero");
	a_stage_step: assert property (
		conv_start && $past(conv_start) |->
		conv_stage == $past(conv_stage) + 4'h1 && conv_stage <= 4'hb)
		else $error("stage order wrong");
	c_last_stage: cover property (conv_start && conv_stage == 4'hb);
	c_shutdown: cover property (powered_down);
	c_read: cover property (reg_rvalid);
endmodule
bind cap_power_cal_ctrl cap_ctrl_properties u_props (.clk, .rst, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .irq_event, .irq_pin,
	.excitation_en, .converter_bias_select, .decimation_ratio,
	.conv_start, .conv_stage, .powered_down);

// [tb/cap_host_model.sv]
// Host model issuing single-word register accesses.
// Assumes strobes are sampled on the rising edge of clk.
`timescale 1ns/1ps
module cap_host_model (
	input  wire logic        clk,        // Core clock
	output logic             reg_wr,     // Write strobe
	output logic             reg_rd,     // Read strobe
	output logic      [15:0] reg_addr,   // Address
	output logic      [15:0] reg_wdata,  // Write data
	input  wire logic [15:0] reg_rdata,  // Read data
	input  wire logic        reg_rvalid  // Read valid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// Released lines flip so a stale value is never mistaken for a request
	task automatic write(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic read(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		// Answer stands only in the cycle after the strobe is taken
		@(negedge clk);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// [tb/cap_power_cal_ctrl_tb_top.sv]
// Testbench: register access, field decode and sequence timing.
// Assumes shortened counts: four cycles full power, eight per delay step.
`timescale 1ns/1ps
module cap_power_cal_ctrl_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        irq_event = 1'b0;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic        irq_pin;
	logic        excitation_en;
	logic [1:0]  converter_bias_select;
	logic [8:0]  decimation_ratio;
	logic        conv_start;
	logic [3:0]  conv_stage;
	logic        conv_cal_en;
	logic [5:0]  sample_skip;
	logic        powered_down;
	logic        seq_busy;
	logic [15:0] v;
	logic [15:0] e;
	int          n;
	int          g;
	int          cyc = 0;
	int          num_errors = 0;
	int          compares = 0;
	cap_host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid);
	cap_power_cal_ctrl #(.FP_CYC(4), .LP_CYC(8)) dut (.clk, .rst, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .irq_event,
		.irq_pin, .excitation_en, .converter_bias_select, .decimation_ratio,
		.conv_start, .conv_stage, .conv_cal_en, .sample_skip, .seq_busy,
		.powered_down);
	initial forever #2 clk = ~clk;
	task automatic print_verdict;
		$display("compares=%0d errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic settle;
		repeat (2) @(negedge clk);
	endtask
	task automatic next_start(output int t);
		do @(negedge clk); while (conv_start !== 1'b1);
		t = cyc;
	endtask
	// Stage count of one sequence and start-to-start spacing
	task automatic measure(input logic [15:0] cal, output int k, output int d);
		int t0;
		int t1;
		next_start(t0);
		k = 0;
		while (conv_start === 1'b1) begin
			chk(conv_cal_en, cal[conv_stage]);
			chk(seq_busy, 1'b1);
			k++;
			@(negedge clk);
		end
		chk(seq_busy, 1'b0);
		next_start(t1);
		d = t1 - t0;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int a = 0; a < 3; a++) begin
			host.read(16'(a), v);
			chk(v, 16'h0000);
		end
		$display("reset values done");
		host.write(16'hfc00, 16'hfbf2);
		host.read(16'h0400, v);
		chk(v, 16'hdbf2);
		settle();
		chk(excitation_en, 1'b0);
		chk(converter_bias_select, 2'h3);
		chk(powered_down, 1'b0);
		for (int k = 0; k < 4; k++) begin
			host.write(16'h0000, 16'(k) << 8);
			settle();
			e = k == 0 ? 16'h0100 : k == 1 ? 16'h0080 : 16'h0040;
			chk(decimation_ratio, e);
			host.write(16'hfc01, {2'(k), 2'(k), 12'h000});
			settle();
			e = k == 0 ? 16'h0003 : k == 1 ? 16'h0007 :
			    k == 2 ? 16'h000f : 16'h001f;
			chk(sample_skip, e);
			host.write(16'h0000, 16'h0002);
			settle();
			chk(sample_skip, 16'(k));
		end
		$display("field decode done");
		for (int m = 1; m < 4; m += 2) begin
			host.write(16'h0000, 16'(m));
			settle();
			chk(powered_down, 1'b1);
			n = 0;
			repeat (40) begin
				@(negedge clk);
				n += int'(conv_start === 1'b1);
			end
			chk(16'(n), 16'h0000);
		end
		host.write(16'h0001, 16'h0a5a);
		host.write(16'h0000, 16'h00b0);
		measure(16'h0a5a, n, g);
		chk(16'(n), 16'h000c);
		chk(16'(g), 16'h0010);
		for (int d = 0; d < 4; d++) begin
			host.write(16'h0000, 16'h0001);
			host.write(16'h0000, 16'h0012 | 16'(d << 2));
			measure(16'h0a5a, n, g);
			chk(16'(g), 16'(2 + 8 * (d + 1)));
		end
		$display("sequence timing done");
		host.write(16'h0000, 16'h0801);
		irq_event = 1'b1;
		settle();
		chk(irq_pin, 1'b1);
		host.write(16'h0000, 16'h0001);
		settle();
		chk(irq_pin, 1'b0);
		host.write(16'h0000, 16'hf6f3);
		host.read(16'h0000, v);
		chk(v, 16'h0000);
		host.read(16'h0001, v);
		chk(v, 16'h0000);
		chk(decimation_ratio, 9'h100);
		$display("interrupt and soft reset done");
		print_verdict();
	end
endmodule
